/* File: rtl/quad_uart_glue.sv */
/*
  Device glue of a four-channel UART: host strobe decode, channel and
  configuration steering, reset handling, strap capture, serial line
  idle levels, modem pins, prescaled sample ticks, timer, interrupt
  source registers and a transmit word queue.
  Assumes all pins are synchronous to ref_clk; serialisers, receive
  FIFOs and flow control live outside and use the ticks and queue.
*/
// Functional notes
// - Transmit line idles high normally, low in infrared mode.
// - Receive line idles high normally, low in infrared mode while function control bit 4 is clear.
// - Infrared receive polarity chosen by function control bit 4.
// - Infrared strap sampled after power-up, hardware and soft reset.
// - Sampled strap lands in bit 6 of every modem control register.
// - Hardware reset returns registers and serial outputs to default.
// - Writing the soft reset register resets all channel registers.
// - Bus strap picks separate strobes or combined strobe protocol.
// - With address bit 7 low, bits 6..4 codes 0..3 pick channel.
// - Request-send and terminal-ready are active-low general outputs.
// - Carrier, ring, clear-send, set-ready are active-low inputs.
// - 16-bit timer may count edges of the external timer clock.
// - Four interrupt source registers sit in configuration space.
// - Transmit word queue carries a trigger level and a level counter.
// - Channel prescaler divides the clock by 1 or 4.
// - Bit tick from 8x or 16x sampling clock.
// - Broadcast bit makes a channel write reach all four channels.
`timescale 1ns/1ns
`default_nettype none
module quad_uart_glue
  import quad_glue_pkg::*;
#(
  parameter int FIFO_DEPTH = 4
) (
  input  wire logic             ref_clk,
  input  wire logic             reset,
  input  wire logic             hwResetN,
  input  wire logic             busStyleSep,
  input  wire logic             chipSelN,
  input  wire logic             readStrobeN,
  input  wire logic             writeStrobeN,
  input  wire logic [7:0]       addr,
  input  wire logic [7:0]       dataIn,
  output logic      [7:0]       dataOut,
  output logic                  dataOutEn,
  output logic                  hostWait,
  input  wire logic             infraredStrap,
  input  wire logic             timerExtClk,
  input  wire logic [NCHAN-1:0] chanIrq,
  input  wire logic             wakeUp,
  input  wire logic [NCHAN-1:0] txActive,
  input  wire logic [NCHAN-1:0] txBit,
  output logic      [NCHAN-1:0] serialOut,
  input  wire logic [NCHAN-1:0] serialIn,
  output logic      [NCHAN-1:0] rxMark,
  output logic      [NCHAN-1:0] requestSendN,
  output logic      [NCHAN-1:0] terminalReadyN,
  input  wire logic [NCHAN-1:0] clearSendN,
  input  wire logic [NCHAN-1:0] setReadyN,
  input  wire logic [NCHAN-1:0] carrierDetectN,
  input  wire logic [NCHAN-1:0] ringIndN,
  output logic      [NCHAN-1:0] sampleTick,
  output logic      [NCHAN-1:0] bitTick,
  output logic                  txWordValid,
  input  wire logic             txWordReady,
  output logic      [7:0]       txWordData,
  output logic      [NCHAN-1:0] txWordChans,
  output logic      [7:0]       txQueueLevel,
  output logic                  txTriggerHit
);
  localparam int TXW = 8 + NCHAN;
  localparam int HCW = $clog2(HW_RESET_MIN_CYC + 1);

  function automatic logic chanMatch(input logic [7:0] a,
                                     input int unsigned ch);
    chanMatch = !a[CFG_SEL_BIT] && !a[6] &&
                (a[5:4] == ch[1:0]);
  endfunction

  bus_state_t       state_r;
  bus_state_t       state_nxt;
  logic [7:0]       mcr_r [NCHAN];
  logic [7:0]       function_ctrl_reg_r [NCHAN];
  logic [7:0]       bcast_r;
  logic [7:0]       sample8x_r;
  logic [7:0]       trigger_r;
  logic [7:0]       tmrCtrl_r;
  logic [15:0]      tmrReload_r;
  logic [15:0]      tmrCnt_r;
  logic             tmrDone_r;
  logic             tmrExt_r;
  logic             tmrExtPrev_r;
  logic [HCW-1:0]   lowCnt_r;
  logic             softRst_r;
  logic             strapLoad_r;
  logic [7:0]       dataOut_r;
  logic [1:0]       preCnt_r [NCHAN];
  logic [3:0]       smpCnt_r [NCHAN];
  logic [NCHAN-1:0] sampleTick_r;
  logic [NCHAN-1:0] bitTick_r;
  logic [NCHAN-1:0] serialOut_r;
  logic [NCHAN-1:0] rxMark_r;
  logic [NCHAN-1:0] rtsN_r;
  logic [NCHAN-1:0] dtrN_r;

  wire              hwRstActive;
  wire              chanRst;
  wire              cfgRst;
  wire              readReq;
  wire              writeReq;
  wire              isTxData;
  wire              writeFire;
  wire              readStart;
  wire              cfgWrite;
  wire              tmrTick;
  wire [6:0]        cfgOff;
  wire [3:0]        chOff;
  wire [1:0]        rdChan;
  wire [NCHAN-1:0]  writeHit;
  wire [NCHAN-1:0]  prescaleTick;
  wire [7:0]        modemStat [NCHAN];
  logic [7:0]       chanRead;
  logic [7:0]       cfgRead;

  fifo_if #(.WIDTH(TXW), .DEPTH(FIFO_DEPTH)) txq ();

  glue_fifo #(.WIDTH(TXW), .DEPTH(FIFO_DEPTH)) txQueue (
    .clk  (ref_clk),
    .rst  (cfgRst),
    .port (txq)
  );

  // A short glitch on the reset pin must not wipe the channels
  assign hwRstActive = lowCnt_r == HCW'(HW_RESET_MIN_CYC);
  assign cfgRst = reset | hwRstActive;
  assign chanRst = cfgRst | softRst_r;

  // Combined style: chip select is the strobe, write pin is read/write
  assign readReq = !chipSelN &&
    (busStyleSep ? !readStrobeN : writeStrobeN);
  assign writeReq = !chipSelN && !writeStrobeN;

  assign cfgOff = addr[6:0];
  assign chOff = addr[3:0];
  assign rdChan = addr[5:4];
  assign isTxData = !addr[CFG_SEL_BIT] && chOff == CH_TX_DATA;
  assign writeFire = state_r == BUS_IDLE && writeReq &&
                     (!isTxData || txq.pushReady);
  assign hostWait = state_r == BUS_IDLE && writeReq && isTxData &&
                    !txq.pushReady;
  assign readStart = state_r == BUS_IDLE && readReq && !writeReq;
  assign cfgWrite = writeFire && addr[CFG_SEL_BIT];

  genvar g;
  generate
    for (g = 0; g < NCHAN; g++)
    begin : chanGen
      assign writeHit[g] = writeFire && !addr[CFG_SEL_BIT] &&
        (bcast_r[BCAST_BIT] || chanMatch(addr, g));
      assign prescaleTick[g] = mcr_r[g][MCR_PRESCALE_BIT] ?
        (preCnt_r[g] == PRESCALE_LAST) : 1'b1;
      assign modemStat[g] = {~carrierDetectN[g], ~ringIndN[g],
        ~setReadyN[g], ~clearSendN[g], 4'h0};
    end
  endgenerate

  assign txq.pushValid = writeFire && isTxData;
  assign txq.pushData = {writeHit, dataIn};
  assign txq.popReady = txWordReady;
  assign txWordValid = txq.popValid;
  assign txWordData = txq.popData[7:0];
  assign txWordChans = txq.popData[TXW-1:8];
  assign txQueueLevel = 8'(txq.level);
  assign txTriggerHit = 8'(txq.level) >= trigger_r;

  assign tmrTick = tmrCtrl_r[TMR_EXT_BIT] ?
    (tmrExt_r && !tmrExtPrev_r) : 1'b1;

  always_comb
  begin
    case (chOff)
      CH_MODEM_CTRL: chanRead = mcr_r[rdChan];
      CH_MODEM_STAT: chanRead = modemStat[rdChan];
      CH_FUNC_CTRL:  chanRead = function_ctrl_reg_r[rdChan];
      default:       chanRead = 8'h00;
    endcase
  end

  always_comb
  begin
    case (cfgOff)
      CFG_INT0:       cfgRead = {4'h0, chanIrq};
      CFG_INT1:       cfgRead = {7'h00, tmrDone_r};
      CFG_INT2:       cfgRead = {7'h00, wakeUp};
      CFG_INT3:       cfgRead = {7'h00, txTriggerHit};
      CFG_TMR_CTRL:   cfgRead = tmrCtrl_r;
      CFG_TMR_LSB:    cfgRead = tmrCnt_r[7:0];
      CFG_TMR_MSB:    cfgRead = tmrCnt_r[15:8];
      CFG_SAMPLE8X:   cfgRead = sample8x_r;
      CFG_TRIGGER:    cfgRead = trigger_r;
      CFG_BROADCAST:  cfgRead = bcast_r;
      default:        cfgRead = 8'h00;
    endcase
  end

  always_comb
  begin
    state_nxt = state_r;
    case (state_r)
      BUS_IDLE:
      begin
        if (writeFire)
          state_nxt = BUS_WRITE;
        else if (readStart)
          state_nxt = BUS_READ;
      end
      BUS_WRITE: if (!writeReq) state_nxt = BUS_IDLE;
      BUS_READ:  if (!readReq) state_nxt = BUS_IDLE;
      default:   state_nxt = BUS_IDLE;
    endcase
  end

  always_ff @(posedge ref_clk)
  begin
    if (reset)
      lowCnt_r <= '0;
    else if (hwResetN)
      lowCnt_r <= '0;
    else if (!hwRstActive)
      lowCnt_r <= HCW'(lowCnt_r + 1'b1);
  end

  always_ff @(posedge ref_clk)
  begin
    state_r <= cfgRst ? BUS_IDLE : state_nxt;
    softRst_r <= !cfgRst && cfgWrite &&
                 cfgOff == CFG_SOFT_RESET;
    strapLoad_r <= chanRst;
    dataOut_r <= cfgRst ? 8'h00 :
      (addr[CFG_SEL_BIT] ? cfgRead : chanRead);
    tmrExt_r <= timerExtClk;
    tmrExtPrev_r <= tmrExt_r;
  end

  always_ff @(posedge ref_clk)
  begin
    if (cfgRst)
    begin
      bcast_r <= CFG_RESET;
      sample8x_r <= CFG_RESET;
      trigger_r <= CFG_RESET;
      tmrCtrl_r <= CFG_RESET;
      tmrReload_r <= TMR_RESET;
    end
    else if (cfgWrite)
    begin
      if (cfgOff == CFG_BROADCAST) bcast_r <= dataIn;
      if (cfgOff == CFG_SAMPLE8X) sample8x_r <= dataIn;
      if (cfgOff == CFG_TRIGGER) trigger_r <= dataIn;
      if (cfgOff == CFG_TMR_CTRL) tmrCtrl_r <= dataIn;
      if (cfgOff == CFG_TMR_LSB) tmrReload_r[7:0] <= dataIn;
      if (cfgOff == CFG_TMR_MSB) tmrReload_r[15:8] <= dataIn;
    end
  end

  // Expiry beats the read-clear in the same cycle
  always_ff @(posedge ref_clk)
  begin
    if (cfgRst || !tmrCtrl_r[TMR_EN_BIT])
      tmrCnt_r <= cfgRst ? TMR_RESET : tmrReload_r;
    else if (tmrTick)
      tmrCnt_r <= (tmrCnt_r == 16'h0000) ? tmrReload_r :
                  16'(tmrCnt_r - 1'b1);
    if (cfgRst)
      tmrDone_r <= 1'b0;
    else if (tmrCtrl_r[TMR_EN_BIT] && tmrTick && tmrCnt_r == 16'h0000)
      tmrDone_r <= 1'b1;
    else if (readStart && addr[CFG_SEL_BIT] && cfgOff == CFG_INT1)
      tmrDone_r <= 1'b0;
  end

  always_ff @(posedge ref_clk)
  begin
    for (int i = 0; i < NCHAN; i++)
    begin
      if (chanRst)
      begin
        mcr_r[i] <= MCR_RESET;
        function_ctrl_reg_r[i] <= FUNCTION_CTRL_REG_RESET;
      end
      else if (strapLoad_r)
        mcr_r[i][MCR_IR_BIT] <= infraredStrap;
      else if (writeHit[i])
      begin
        if (chOff == CH_MODEM_CTRL) mcr_r[i] <= dataIn;
        if (chOff == CH_FUNC_CTRL) function_ctrl_reg_r[i] <= dataIn;
      end
    end
  end

  always_ff @(posedge ref_clk)
  begin
    for (int i = 0; i < NCHAN; i++)
    begin
      if (chanRst)
      begin
        preCnt_r[i] <= 2'h0;
        smpCnt_r[i] <= 4'h0;
        sampleTick_r[i] <= 1'b0;
        bitTick_r[i] <= 1'b0;
      end
      else
      begin
        preCnt_r[i] <= 2'(preCnt_r[i] + 1'b1);
        sampleTick_r[i] <= prescaleTick[i];
        bitTick_r[i] <= prescaleTick[i] && smpCnt_r[i] ==
          (sample8x_r[i] ? SAMPLE8_LAST : SAMPLE16_LAST);
        if (prescaleTick[i])
          smpCnt_r[i] <= (smpCnt_r[i] == (sample8x_r[i] ?
            SAMPLE8_LAST : SAMPLE16_LAST)) ? 4'h0 :
            4'(smpCnt_r[i] + 1'b1);
      end
    end
  end

  // Infrared bit 4 high selects a high-idle decoder front end
  always_ff @(posedge ref_clk)
  begin
    for (int i = 0; i < NCHAN; i++)
    begin
      serialOut_r[i] <= chanRst ? 1'b1 : (txActive[i] ? txBit[i] :
        ~mcr_r[i][MCR_IR_BIT]);
      rxMark_r[i] <= chanRst ? 1'b1 : (!mcr_r[i][MCR_IR_BIT] ?
        serialIn[i] :
        (function_ctrl_reg_r[i][FUNCTION_CTRL_REG_RXPOL_BIT] ? serialIn[i] :
        ~serialIn[i]));
      rtsN_r[i] <= chanRst ? 1'b1 : ~mcr_r[i][MCR_RTS_BIT];
      dtrN_r[i] <= chanRst ? 1'b1 : ~mcr_r[i][MCR_DTR_BIT];
    end
  end

  assign dataOut = dataOut_r;
  assign dataOutEn = state_r == BUS_READ;
  assign serialOut = serialOut_r;
  assign rxMark = rxMark_r;
  assign requestSendN = rtsN_r;
  assign terminalReadyN = dtrN_r;
  assign sampleTick = sampleTick_r;
  assign bitTick = bitTick_r;

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (reset);

  sequence hwLowRun;
    !hwResetN [*5];
  endsequence

  sequence combinedRead;
    state_r == BUS_IDLE && !busStyleSep && !chipSelN && writeStrobeN;
  endsequence

  AST_TX_IDLE: assert property (!chanRst && !txActive[2] |=>
    serialOut[2] == ~$past(mcr_r[2][MCR_IR_BIT]))
    else $error("transmit idle level wrong");
  AST_RX_IR_POL: assert property (!chanRst &&
    mcr_r[1][MCR_IR_BIT] && !function_ctrl_reg_r[1][FUNCTION_CTRL_REG_RXPOL_BIT] |=>
    rxMark[1] == ~$past(serialIn[1]))
    else $error("infrared receive polarity wrong");
  AST_STRAP_LOAD: assert property ($fell(chanRst) |=>
    mcr_r[3][MCR_IR_BIT] == $past(infraredStrap))
    else $error("strap not loaded after reset");
  AST_HW_RESET: assert property (hwLowRun |=>
    chanRst ##1 (serialOut == '1 && requestSendN == '1))
    else $error("hardware reset not applied");
  AST_SOFT_RESET: assert property (cfgWrite &&
    cfgOff == CFG_SOFT_RESET |-> ##2 function_ctrl_reg_r[0] == FUNCTION_CTRL_REG_RESET)
    else $error("soft reset missed channel");
  AST_BUS_STYLE: assert property (combinedRead |=>
    state_r == BUS_READ && dataOutEn)
    else $error("combined strobe read not taken");
  AST_CHAN_DECODE: assert property (writeFire && !chanRst &&
    !strapLoad_r && !bcast_r[BCAST_BIT] && addr[7:4] == 4'h2 &&
    chOff == CH_MODEM_CTRL |=> mcr_r[2] == $past(dataIn) &&
    mcr_r[1] == $past(mcr_r[1]))
    else $error("channel decode wrong");
  AST_BROADCAST: assert property (writeHit[0] &&
    bcast_r[BCAST_BIT] && !chanRst && !strapLoad_r &&
    chOff == CH_MODEM_CTRL |=> mcr_r[3] == $past(dataIn))
    else $error("broadcast write missed channel");
  AST_CFG_STEER: assert property (cfgWrite && !chanRst &&
    !strapLoad_r && cfgOff == CFG_TRIGGER |=>
    trigger_r == $past(dataIn) && mcr_r[0] == $past(mcr_r[0]))
    else $error("configuration write leaked");
  AST_PRESCALE: assert property (sampleTick_r[0] &&
    $past(mcr_r[0][MCR_PRESCALE_BIT]) && !$past(chanRst) |->
    $past(preCnt_r[0]) == PRESCALE_LAST)
    else $error("prescaler tick early");
endmodule
`default_nettype wire

/* File: rtl/quad_glue_pkg.sv */
/*
  Constants of the quad UART host-side glue: address decode, register
  offsets, field positions, reset values and cycle counts.
  Assumes a single 125 MHz clock.
*/
package quad_glue_pkg;
  localparam int NCHAN = 4;
  localparam int CLK_PERIOD_NS = 8;
  localparam int HW_RESET_MIN_NS = 40;
  localparam int HW_RESET_MIN_CYC =
    (HW_RESET_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CFG_SEL_BIT = 7;
  localparam int CHAN_FIFO_BYTES = 64;
  localparam logic [3:0] CH_TX_DATA = 4'h0;
  localparam logic [3:0] CH_MODEM_CTRL = 4'h4;
  localparam logic [3:0] CH_MODEM_STAT = 4'h6;
  localparam logic [3:0] CH_FUNC_CTRL = 4'h8;
  localparam logic [6:0] CFG_INT0 = 7'h00;
  localparam logic [6:0] CFG_INT1 = 7'h01;
  localparam logic [6:0] CFG_INT2 = 7'h02;
  localparam logic [6:0] CFG_INT3 = 7'h03;
  localparam logic [6:0] CFG_TMR_CTRL = 7'h04;
  localparam logic [6:0] CFG_TMR_LSB = 7'h06;
  localparam logic [6:0] CFG_TMR_MSB = 7'h07;
  localparam logic [6:0] CFG_SAMPLE8X = 7'h08;
  localparam logic [6:0] CFG_TRIGGER = 7'h09;
  localparam logic [6:0] CFG_SOFT_RESET = 7'h0a;
  localparam logic [6:0] CFG_BROADCAST = 7'h0f;
  localparam int MCR_DTR_BIT = 0;
  localparam int MCR_RTS_BIT = 1;
  localparam int MCR_IR_BIT = 6;
  localparam int MCR_PRESCALE_BIT = 7;
  localparam int FUNCTION_CTRL_REG_RXPOL_BIT = 4;
  localparam int BCAST_BIT = 0;
  localparam int TMR_EN_BIT = 0;
  localparam int TMR_EXT_BIT = 1;
  localparam logic [7:0] MCR_RESET = 8'h00;
  localparam logic [7:0] FUNCTION_CTRL_REG_RESET = 8'h00;
  localparam logic [7:0] CFG_RESET = 8'h00;
  localparam logic [15:0] TMR_RESET = 16'h0000;
  localparam logic [1:0] PRESCALE_LAST = 2'h3;
  localparam logic [3:0] SAMPLE16_LAST = 4'hf;
  localparam logic [3:0] SAMPLE8_LAST = 4'h7;
  typedef enum logic [2:0] {
    BUS_IDLE  = 3'b001,
    BUS_WRITE = 3'b010,
    BUS_READ  = 3'b100
  } bus_state_t;
endpackage

/* File: rtl/fifo_if.sv */
/*
  Push/pop carrier between the glue top and its transmit word queue.
  Assumes both ends share one clock.
*/
`timescale 1ns/1ns
`default_nettype none
interface fifo_if #(
  parameter int WIDTH = 12,
  parameter int DEPTH = 4
);
  localparam int CW = $clog2(DEPTH + 1);
  logic             pushValid;
  logic             pushReady;
  logic [WIDTH-1:0] pushData;
  logic             popValid;
  logic             popReady;
  logic [WIDTH-1:0] popData;
  logic [CW-1:0]    level;
  modport fill  (output pushValid, pushData, input pushReady, level);
  modport drain (output popReady, input popValid, popData);
  modport store (input pushValid, pushData, popReady,
                 output pushReady, popValid, popData, level);
endinterface
`default_nettype wire

/* File: rtl/glue_fifo.sv */
/*
  Small flip-flop FIFO with valid/ready on both sides and a level count.
  Assumes a synchronous active-high reset.
*/
`timescale 1ns/1ns
`default_nettype none
module glue_fifo #(
  parameter int WIDTH = 12,
  parameter int DEPTH = 4
) (
  input wire logic clk,
  input wire logic rst,
  fifo_if.store    port
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int CW = $clog2(DEPTH + 1);

  function automatic logic [AW-1:0] nextPtr(input logic [AW-1:0] p);
    nextPtr = (p == AW'(DEPTH - 1)) ? '0 : AW'(p + 1'b1);
  endfunction

  logic [WIDTH-1:0] mem_r [DEPTH];
  logic [AW-1:0]    wrPtr_r;
  logic [AW-1:0]    rdPtr_r;
  logic [CW-1:0]    count_r;
  wire              doPush;
  wire              doPop;

  assign doPush = port.pushValid & port.pushReady;
  assign doPop = port.popValid & port.popReady;
  assign port.pushReady = count_r != CW'(DEPTH);
  assign port.popValid = count_r != '0;
  assign port.popData = mem_r[rdPtr_r];
  assign port.level = count_r;

  always_ff @(posedge clk)
  begin
    if (doPush)
    begin
      mem_r[wrPtr_r] <= port.pushData;
    end
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      wrPtr_r <= '0;
      rdPtr_r <= '0;
      count_r <= '0;
    end
    else
    begin
      if (doPush)
        wrPtr_r <= nextPtr(wrPtr_r);
      if (doPop)
        rdPtr_r <= nextPtr(rdPtr_r);
      count_r <= CW'(count_r + CW'(doPush) - CW'(doPop));
    end
  end

  AST_FIFO_BOUND: assert property (@(posedge clk) disable iff (rst)
    count_r <= CW'(DEPTH))
    else $error("fifo level above depth");
endmodule
`default_nettype wire

/* File: bench/line_far_end.sv */
/*
  Far side of the serial lines and of the transmit word queue: holds the
  receive lines at a chosen level and pops queued words unless stalled.
  Assumes the glue top on the same clock.
*/
`timescale 1ns/1ns
`default_nettype none
module line_far_end (
  input  wire logic       ref_clk,
  input  wire logic       stall,
  input  wire logic [3:0] lineLevel,
  input  wire logic       txWordValid,
  output logic            txWordReady,
  output logic      [3:0] serialIn,
  output logic      [7:0] popCount
);
  // Lines never float: the bench always names a level
  assign serialIn = lineLevel;
  initial
  begin
    popCount = 8'h00;
    txWordReady = 1'b0;
  end
  // Ready changes just after the edge, like any other driver here
  always @(posedge ref_clk)
  begin
    if (txWordValid === 1'b1 && txWordReady)
      popCount <= popCount + 8'h01;
    txWordReady <= #1 !stall;
  end
endmodule
`default_nettype wire

/* File: bench/quad_uart_host_select_reset_bench.sv */
/*
  Self-checking bench of the quad UART glue: host bus tasks, pin checks,
  reset, strap, broadcast and queue sequences.
  Assumes the glue package and the far-end model are compiled first.
*/
`timescale 1ns/1ns
`default_nettype none
module quad_uart_host_select_reset_bench;
  import quad_glue_pkg::*;
  logic       ref_clk = 1'b0;
  logic       reset = 1'b1;
  logic       hwResetN = 1'b1;
  logic       busStyleSep = 1'b1;
  logic       chipSelN = 1'b1;
  logic       readStrobeN = 1'b1;
  logic       writeStrobeN = 1'b1;
  logic [7:0] addr = 8'h00;
  logic [7:0] dataIn = 8'h00;
  logic       infraredStrap = 1'b0;
  logic [3:0] chanIrq = 4'h0;
  logic [3:0] clearSendN = 4'hf;
  logic [3:0] setReadyN = 4'hf;
  logic [3:0] carrierDetectN = 4'hf;
  logic [3:0] ringIndN = 4'hf;
  logic       stall = 1'b1;
  logic       timerExtClk = 1'b0;
  logic [3:0] sampleTick, bitTick;
  logic [3:0] lineLevel = 4'hf;
  logic [7:0] dataOut, txWordData, txQueueLevel, popCount;
  logic [3:0] serialOut, serialIn, rxMark, requestSendN, terminalReadyN;
  logic [3:0] txWordChans;
  logic       dataOutEn, hostWait, txWordValid, txWordReady, txTriggerHit;
  int         nFail = 0;
  int         samplesChecked = 0;

  quad_uart_glue #(.FIFO_DEPTH(4)) DUT (
    .ref_clk(ref_clk), .reset(reset), .hwResetN(hwResetN),
    .busStyleSep(busStyleSep), .chipSelN(chipSelN),
    .readStrobeN(readStrobeN), .writeStrobeN(writeStrobeN),
    .addr(addr), .dataIn(dataIn), .dataOut(dataOut),
    .dataOutEn(dataOutEn), .hostWait(hostWait),
    .infraredStrap(infraredStrap), .timerExtClk(timerExtClk),
    .chanIrq(chanIrq), .wakeUp(1'b0), .txActive(4'h0), .txBit(4'h0),
    .serialOut(serialOut), .serialIn(serialIn), .rxMark(rxMark),
    .requestSendN(requestSendN), .terminalReadyN(terminalReadyN),
    .clearSendN(clearSendN), .setReadyN(setReadyN),
    .carrierDetectN(carrierDetectN), .ringIndN(ringIndN),
    .sampleTick(sampleTick), .bitTick(bitTick),
    .txWordValid(txWordValid),
    .txWordReady(txWordReady), .txWordData(txWordData),
    .txWordChans(txWordChans), .txQueueLevel(txQueueLevel),
    .txTriggerHit(txTriggerHit));

  line_far_end farEnd (
    .ref_clk(ref_clk), .stall(stall), .lineLevel(lineLevel),
    .txWordValid(txWordValid), .txWordReady(txWordReady),
    .serialIn(serialIn), .popCount(popCount));

  initial
  begin
    forever #4 ref_clk = ~ref_clk;
  end

  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask

  task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
    samplesChecked++;
    if (got !== exp)
    begin
      nFail++;
      $display("BAD %0t byte %h expected %h", $time, got, exp);
    end
  endtask

  task automatic chk4(input logic [3:0] got, input logic [3:0] exp);
    samplesChecked++;
    if (got !== exp)
    begin
      nFail++;
      $display("BAD %0t pins %b expected %b", $time, got, exp);
    end
  endtask

  // Request held until taken; a full queue stretches it via hostWait
  task automatic hostWrite(input logic [7:0] a, input logic [7:0] d);
    int n;
    n = 0;
    chipSelN = 1'b0;
    writeStrobeN = 1'b0;
    addr = a;
    dataIn = d;
    while (hostWait === 1'b1 && n < 50)
    begin
      tick(1);
      n++;
    end
    if (n == 50)
      nFail++;
    tick(1);
    chipSelN = 1'b1;
    writeStrobeN = 1'b1;
    tick(2);
  endtask

  task automatic hostRead(input logic [7:0] a, input logic [7:0] exp);
    chipSelN = 1'b0;
    addr = a;
    if (busStyleSep)
      readStrobeN = 1'b0;
    tick(2);
    chk8(dataOut, exp);
    chipSelN = 1'b1;
    readStrobeN = 1'b1;
    tick(2);
  endtask

  task automatic end_of_test();
    if (nFail == 0 && samplesChecked > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  initial
  begin
    int n;
    int s0;
    int s1;
    int b1;
    int b2;
    tick(6);
    reset = 1'b0;
    tick(3);
    chk4(serialOut, 4'hf);
    chk4(rxMark, 4'hf);
    chk4(requestSendN, 4'hf);
    for (int c = 0; c < 4; c++)
    begin
      hostWrite({1'b0, 3'(c), CH_MODEM_CTRL}, 8'h01);
      tick(2);
      chk4(terminalReadyN, 4'(4'hf << (c + 1)));
    end
    // Channel code 4 maps to no channel
    hostWrite(8'h44, 8'h02);
    tick(2);
    chk4(requestSendN, 4'hf);
    hostRead(8'h24, 8'h01);
    clearSendN = 4'hd;
    setReadyN = 4'hd;
    ringIndN = 4'hd;
    hostRead(8'h16, 8'h70);
    hostWrite(8'h89, 8'h02);
    hostRead(8'h89, 8'h02);
    chanIrq = 4'h5;
    hostRead(8'h80, 8'h05);
    hostRead(8'h8c, 8'h00);
    hostWrite(8'h8f, 8'h01);
    hostWrite(8'h14, 8'h02);
    tick(2);
    chk4(requestSendN, 4'h0);
    chk4(terminalReadyN, 4'hf);
    hostWrite(8'h8f, 8'h00);
    // A pulse of four cycles is too short to count as a reset
    hwResetN = 1'b0;
    tick(4);
    hwResetN = 1'b1;
    tick(3);
    chk4(requestSendN, 4'h0);
    hwResetN = 1'b0;
    tick(7);
    chk4(requestSendN, 4'hf);
    chk4(serialOut, 4'hf);
    infraredStrap = 1'b1;
    hwResetN = 1'b1;
    tick(4);
    chk4(serialOut, 4'h0);
    hostRead(8'h04, 8'h40);
    hostWrite(8'h34, 8'h03);
    tick(2);
    chk4(serialOut, 4'h8);
    hostWrite(8'h8a, 8'h00);
    tick(4);
    chk4(requestSendN, 4'hf);
    chk4(serialOut, 4'h0);
    hostRead(8'h34, 8'h40);
    lineLevel = 4'h0;
    tick(3);
    chk4(rxMark, 4'hf);
    hostWrite(8'h18, 8'h10);
    lineLevel = 4'h3;
    tick(3);
    chk4(rxMark, 4'he);
    busStyleSep = 1'b0;
    hostRead(8'h18, 8'h10);
    hostWrite(8'h89, 8'h01);
    hostRead(8'h89, 8'h01);
    busStyleSep = 1'b1;
    // Far side stalls while the queue fills and refuses a fifth word
    for (int i = 0; i < 4; i++)
      hostWrite(8'h20, 8'(8'ha0 + i));
    chk8(txQueueLevel, 8'h04);
    chk4({3'b000, txTriggerHit}, 4'h1);
    chk8(txWordData, 8'ha0);
    chk4(txWordChans, 4'h4);
    chipSelN = 1'b0;
    writeStrobeN = 1'b0;
    addr = 8'h20;
    dataIn = 8'ha4;
    tick(2);
    chk4({3'b000, hostWait}, 4'h1);
    stall = 1'b0;
    hostWrite(8'h20, 8'ha4);
    n = 0;
    while (txWordValid !== 1'b0 && n < 40)
    begin
      tick(1);
      n++;
    end
    chk8(popCount, 8'h05);
    chk8(txQueueLevel, 8'h00);
    // Channel 0 divides by four, channel 2 runs 8x sampling
    hostWrite(8'h04, 8'h80);
    hostWrite(8'h88, 8'h04);
    tick(16);
    s0 = 0;
    s1 = 0;
    b1 = 0;
    b2 = 0;
    for (int i = 0; i < 64; i++)
    begin
      tick(1);
      s0 += sampleTick[0];
      s1 += sampleTick[1];
      b1 += bitTick[1];
      b2 += bitTick[2];
    end
    chk8(8'(s0), 8'h10);
    chk8(8'(s1), 8'h40);
    chk8(8'(b1), 8'h04);
    chk8(8'(b2), 8'h08);
    // Two external rising edges take the count from 2 down to 0
    hostWrite(8'h86, 8'h02);
    hostWrite(8'h84, 8'h03);
    repeat (2)
    begin
      timerExtClk = 1'b1;
      tick(2);
      timerExtClk = 1'b0;
      tick(2);
    end
    hostRead(8'h86, 8'h00);
    end_of_test();
  end

  initial
  begin
    #100000;
    nFail++;
    end_of_test();
  end
endmodule
`default_nettype wire
